// ===== hdl/asp_regs.svh
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
// Register indices; byte address is four times the index
`define ASP_IDX_CTRL_A     14'h1F91
`define ASP_IDX_STATUS     14'h1F91
`define ASP_IDX_CTRL_B     14'h1F92
`define ASP_IDX_BUFFER     14'h1F93
`define ASP_IDX_PIN_ROUTE  14'h1F94
// Control A fields
`define ASP_CA_TX_EN       7
`define ASP_CA_RX_EN       6
`define ASP_CA_TX_STOP     5
`define ASP_CA_EVEN        4
`define ASP_CA_PAR_EN      3
// Control B fields
`define ASP_CB_FILT_HI     2
`define ASP_CB_FILT_LO     1
`define ASP_CB_RX_STOP     0
// Pin route fields
`define ASP_PR_RX_SEL      0
`define ASP_PR_TX_SEL      1
// Status fields
`define ASP_ST_PARITY_ERR_FLAG        7
`define ASP_ST_FRAMING_ERR_FLAG        6
`define ASP_ST_OVERRUN_ERR_FLAG        5
`define ASP_ST_FULL        4
`define ASP_ST_DONE        3
`define ASP_ST_EMPTY       2
// Reset values
`define ASP_RST_CTRL       8'h00
`define ASP_RST_BUF        8'h00
// Baud divisors in fc cycles per tick
`define ASP_DIV_0          9'd13
`define ASP_DIV_1          9'd26
`define ASP_DIV_2          9'd52
`define ASP_DIV_3          9'd104
`define ASP_DIV_4          9'd208
`define ASP_DIV_5          9'd416
`define ASP_DIV_7          9'd96
`define ASP_BAUD_TIMER     3'b110
// Ticks per bit and majority sample points
`define ASP_TICK_LAST      4'd15
`define ASP_SAMPLE_A       4'd7
`define ASP_SAMPLE_B       4'd8
`define ASP_SAMPLE_C       4'd9
// Glitch filter lengths in fc cycles
`define ASP_FILT_1         7'd31
`define ASP_FILT_2         7'd63
`define ASP_FILT_3         7'd127
`endif

// ===== hdl/asp_pkg.sv
package asp_pkg;
	typedef enum logic [4:0] {
		ASP_IDLE   = 5'b00001,
		ASP_START  = 5'b00010,
		ASP_DATA   = 5'b00100,
		ASP_PARITY = 5'b01000,
		ASP_STOP   = 5'b10000
	} asp_state_t;
endpackage

// ===== hdl/asp_serial_port.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_serial_port (
	input  wire logic        pclk,              // System clock fc
	input  wire logic        presetn,           // Asynchronous reset, active low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB direction
	input  wire logic [15:0] paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error on unmapped address
	input  wire logic        timer4_irq,        // Timer pulse used as tick source
	input  wire logic        serial_in_first,   // First receive pin
	input  wire logic        serial_in_second,  // Second receive pin
	output logic             serial_out_first,  // First transmit pin
	output logic             serial_out_second, // Second transmit pin
	output logic             tx_irq,            // Transmit start event pulse
	output logic             rx_irq             // Receive complete event pulse when the frame loads an empty buffer
);
	logic [7:0]  ctrl_a;
	logic [2:0]  ctrl_b;
	logic [1:0]  pin_route;
	logic [7:0]  rx_buf;
	logic [7:0]  tx_buf;
	logic        tx_empty, tx_done, rx_full, parity_err_flag, framing_err_flag, overrun_err_flag, stat_seen;
	logic [13:0] idx;
	logic        acc, wr, rd, hit;
	logic        baud_tick, gap_ok;
	logic [8:0]  div_cnt, div_val, tick_gap;
	logic [1:0]  sync_a, sync_b;
	logic        rx_raw, rx_filt;
	logic [6:0]  filt_cnt, filt_len;
	asp_pkg::asp_state_t tx_state, rx_state;
	logic [3:0]  tx_rt, rx_rt;
	logic [2:0]  tx_bit, rx_bit;
	logic        tx_stop_n, rx_stop_n;
	logic [7:0]  tx_shift, rx_shift;
	logic        tx_line, tx_par_q, tx_load;
	logic [2:0]  rx_smp;
	logic        rx_vote, rx_parity_err_flag, rx_framing_err_flag, rx_end;
	logic        tx_en, rx_en, par_en, even, tx_two, rx_two;

	assign tx_en  = ctrl_a[`ASP_CA_TX_EN];
	assign rx_en  = ctrl_a[`ASP_CA_RX_EN];
	assign par_en = ctrl_a[`ASP_CA_PAR_EN];
	assign even   = ctrl_a[`ASP_CA_EVEN];
	assign tx_two = ctrl_a[`ASP_CA_TX_STOP];
	assign rx_two = ctrl_b[`ASP_CB_RX_STOP];

	// APB decode; zero wait states keep the master simple
	assign idx     = paddr[15:2];
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign rd      = acc & ~pwrite;
	assign hit     = (idx == `ASP_IDX_CTRL_A) | (idx == `ASP_IDX_CTRL_B) |
	                 (idx == `ASP_IDX_BUFFER) | (idx == `ASP_IDX_PIN_ROUTE);
	assign pready  = acc;
	assign pslverr = acc & ~hit;

	// Read mux; write-only control B reads as zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			case (idx)
				`ASP_IDX_STATUS:    prdata[7:2] = {parity_err_flag, framing_err_flag, overrun_err_flag, rx_full, tx_done, tx_empty};
				`ASP_IDX_BUFFER:    prdata[7:0] = rx_buf;
				`ASP_IDX_PIN_ROUTE: prdata[1:0] = pin_route;
				default:            prdata = 32'h0000_0000;
			endcase
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a    <= `ASP_RST_CTRL;
			ctrl_b    <= 3'h0;
			pin_route <= 2'h0;
		end else if (wr) begin
			if (idx == `ASP_IDX_CTRL_A)
				ctrl_a <= pwdata[7:0];
			if (idx == `ASP_IDX_CTRL_B)
				ctrl_b <= pwdata[2:0];
			if (idx == `ASP_IDX_PIN_ROUTE)
				pin_route <= pwdata[1:0];
		end
	end

	// Baud divisor select
	always_comb begin
		case (ctrl_a[2:0])
			3'b000:  div_val = `ASP_DIV_0;
			3'b001:  div_val = `ASP_DIV_1;
			3'b010:  div_val = `ASP_DIV_2;
			3'b011:  div_val = `ASP_DIV_3;
			3'b100:  div_val = `ASP_DIV_4;
			3'b101:  div_val = `ASP_DIV_5;
			default: div_val = `ASP_DIV_7;
		endcase
	end

	// One tick source for both directions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_cnt <= 9'h000;
		else if (div_cnt >= div_val - 9'd1)
			div_cnt <= 9'h000;
		else
			div_cnt <= div_cnt + 9'd1;
	end
	assign baud_tick = (ctrl_a[2:0] == `ASP_BAUD_TIMER) ? timer4_irq : (div_cnt >= div_val - 9'd1);

	// Cycles since the last tick feed the spacing check; a code write voids one gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_gap <= 9'h000;
			gap_ok   <= 1'b0;
		end else begin
			tick_gap <= baud_tick ? 9'h000 : tick_gap + 9'd1;
			gap_ok   <= (gap_ok | baud_tick) & ~(wr && idx == `ASP_IDX_CTRL_A);
		end
	end

	// Pin synchronisers; only the second stage is looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 2'b11;
			sync_b <= 2'b11;
		end else begin
			sync_a <= {sync_a[0], serial_in_first};
			sync_b <= {sync_b[0], serial_in_second};
		end
	end
	assign rx_raw = pin_route[`ASP_PR_RX_SEL] ? sync_b[1] : sync_a[1];

	always_comb begin
		case (ctrl_b[`ASP_CB_FILT_HI:`ASP_CB_FILT_LO])
			2'b01:   filt_len = `ASP_FILT_1;
			2'b10:   filt_len = `ASP_FILT_2;
			default: filt_len = `ASP_FILT_3;
		endcase
	end

	// Level must hold the full filter length before it is accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_filt  <= 1'b1;
			filt_cnt <= 7'h00;
		end else if (ctrl_b[`ASP_CB_FILT_HI:`ASP_CB_FILT_LO] == 2'b00) begin
			rx_filt  <= rx_raw;
			filt_cnt <= 7'h00;
		end else if (rx_raw == rx_filt) begin
			filt_cnt <= 7'h00;
		end else if (filt_cnt >= filt_len - 7'd1) begin
			rx_filt  <= rx_raw;
			filt_cnt <= 7'h00;
		end else begin
			filt_cnt <= filt_cnt + 7'd1;
		end
	end

	// Engine starts only on enable; a frame in flight ignores later disable
	assign tx_load = (tx_state == asp_pkg::ASP_IDLE) & tx_en & ~tx_empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state  <= asp_pkg::ASP_IDLE;
			tx_rt     <= 4'h0;
			tx_bit    <= 3'h0;
			tx_stop_n <= 1'b0;
			tx_shift  <= `ASP_RST_BUF;
			tx_line   <= 1'b1;
		end else if (tx_load) begin
			tx_state  <= asp_pkg::ASP_START;
			tx_shift  <= tx_buf;
			tx_rt     <= 4'h0;
			tx_bit    <= 3'h0;
			tx_stop_n <= 1'b0;
			tx_line   <= 1'b0;
		end else if (baud_tick && tx_state != asp_pkg::ASP_IDLE) begin
			tx_rt <= tx_rt + 4'd1;
			if (tx_rt == `ASP_TICK_LAST) begin
				case (tx_state)
					asp_pkg::ASP_START: begin
						tx_state <= asp_pkg::ASP_DATA;
						tx_line  <= tx_shift[0];
					end
					asp_pkg::ASP_DATA: begin
						tx_bit <= tx_bit + 3'd1;
						if (tx_bit == 3'd7) begin
							tx_state <= par_en ? asp_pkg::ASP_PARITY : asp_pkg::ASP_STOP;
							tx_line  <= par_en ? tx_par_q : 1'b1;
						end else begin
							tx_shift <= {1'b0, tx_shift[7:1]};
							tx_line  <= tx_shift[1];
						end
					end
					asp_pkg::ASP_PARITY: begin
						tx_state <= asp_pkg::ASP_STOP;
						tx_line  <= 1'b1;
					end
					asp_pkg::ASP_STOP: begin
						tx_stop_n <= 1'b1;
						if (tx_stop_n || !tx_two)
							tx_state <= asp_pkg::ASP_IDLE;
					end
					default: tx_state <= asp_pkg::ASP_IDLE;
				endcase
			end
		end
	end

	// Parity is formed from tx_buf as the shifter loads, before the first shift
	// so it is latched separately at load time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_par_q <= 1'b0;
		else if (tx_load)
			tx_par_q <= even ? ^tx_buf : ~^tx_buf;
	end

	// Pin drive; idle line is high
	always_comb begin
		serial_out_first  = 1'b1;
		serial_out_second = 1'b1;
		if (pin_route[`ASP_PR_TX_SEL])
			serial_out_second = tx_line;
		else
			serial_out_first  = tx_line;
	end

	// Receiver: start on low, sample ticks 7-9, decide on tick 15
	assign rx_vote = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2]) | (rx_smp[1] & rx_smp[2]);
	assign rx_end  = baud_tick && rx_rt == `ASP_TICK_LAST && rx_state == asp_pkg::ASP_STOP &&
	                 (rx_stop_n || !rx_two);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state  <= asp_pkg::ASP_IDLE;
			rx_rt     <= 4'h0;
			rx_bit    <= 3'h0;
			rx_smp    <= 3'h0;
			rx_stop_n <= 1'b0;
			rx_shift  <= 8'h00;
			rx_parity_err_flag   <= 1'b0;
			rx_framing_err_flag   <= 1'b0;
		end else if (rx_state == asp_pkg::ASP_IDLE) begin
			rx_rt     <= 4'h0;
			rx_bit    <= 3'h0;
			rx_stop_n <= 1'b0;
			rx_framing_err_flag   <= 1'b0;
			if (rx_en && !overrun_err_flag && !rx_filt)
				rx_state <= asp_pkg::ASP_START;
		end else if (baud_tick) begin
			rx_rt <= rx_rt + 4'd1;
			if (rx_rt == `ASP_SAMPLE_A)
				rx_smp[0] <= rx_filt;
			if (rx_rt == `ASP_SAMPLE_B)
				rx_smp[1] <= rx_filt;
			if (rx_rt == `ASP_SAMPLE_C)
				rx_smp[2] <= rx_filt;
			if (rx_rt == `ASP_TICK_LAST) begin
				case (rx_state)
					asp_pkg::ASP_START:
						rx_state <= rx_vote ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA; // False start rejected
					asp_pkg::ASP_DATA: begin
						rx_shift <= {rx_vote, rx_shift[7:1]};
						rx_bit   <= rx_bit + 3'd1;
						if (rx_bit == 3'd7)
							rx_state <= par_en ? asp_pkg::ASP_PARITY : asp_pkg::ASP_STOP;
					end
					asp_pkg::ASP_PARITY: begin
						rx_parity_err_flag  <= rx_vote != (even ? ^rx_shift : ~^rx_shift);
						rx_state <= asp_pkg::ASP_STOP;
					end
					asp_pkg::ASP_STOP: begin
						rx_stop_n <= 1'b1;
						if (!rx_vote)
							rx_framing_err_flag <= 1'b1;
						if (rx_stop_n || !rx_two)
							rx_state <= asp_pkg::ASP_IDLE;
					end
					default: rx_state <= asp_pkg::ASP_IDLE;
				endcase
			end
		end
	end

	// Status and buffers; hardware set wins over software clear
	logic rd_clear, tx_accept;
	assign rd_clear  = rd && idx == `ASP_IDX_BUFFER && stat_seen;
	assign tx_accept = wr && idx == `ASP_IDX_BUFFER && stat_seen && tx_empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_seen <= 1'b0;
			tx_buf    <= `ASP_RST_BUF;
			tx_empty  <= 1'b1;
			rx_buf    <= `ASP_RST_BUF;
			rx_full   <= 1'b0;
			parity_err_flag      <= 1'b0;
			framing_err_flag      <= 1'b0;
			overrun_err_flag      <= 1'b0;
			tx_irq    <= 1'b0;
			rx_irq    <= 1'b0;
		end else begin
			tx_irq <= tx_load;
			rx_irq <= rx_end & ~rx_full;
			if (rd && idx == `ASP_IDX_STATUS)
				stat_seen <= 1'b1;
			else if (acc && idx == `ASP_IDX_BUFFER)
				stat_seen <= 1'b0;
			if (tx_accept) begin
				tx_buf   <= pwdata[7:0];
				tx_empty <= ~tx_en;
			end else if (tx_load || (!tx_en && tx_state == asp_pkg::ASP_IDLE)) begin
				tx_empty <= 1'b1;
			end
			if (rd_clear) begin
				rx_full <= 1'b0;
				parity_err_flag    <= 1'b0;
				framing_err_flag    <= 1'b0;
				overrun_err_flag    <= 1'b0;
			end
			if (rx_end) begin
				if (rx_full) begin
					overrun_err_flag <= 1'b1;
				end else begin
					rx_buf  <= rx_shift;
					rx_full <= 1'b1;
					parity_err_flag    <= rx_parity_err_flag & par_en;
					framing_err_flag    <= rx_framing_err_flag | ~rx_vote;
				end
			end
		end
	end

	// Done flag drops as a frame loads and rises once the engine is idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_done <= 1'b1;
		else if (tx_load)
			tx_done <= 1'b0;
		else if (tx_state == asp_pkg::ASP_IDLE)
			tx_done <= 1'b1;
	end

	a_done_busy: assert property (@(posedge pclk) disable iff (!presetn)
		tx_state != asp_pkg::ASP_IDLE |-> !tx_done) else $error("done flag high while sending");
	a_irq_empty: assert property (@(posedge pclk) disable iff (!presetn)
		tx_irq |-> tx_empty) else $error("tx_irq without empty flag");
	a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
		tx_state == asp_pkg::ASP_START |-> !tx_line) else $error("start bit not low");
	a_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
		tx_state == asp_pkg::ASP_IDLE |-> serial_out_first && serial_out_second) else $error("idle line low");
	a_div_first: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_a[2:0] == 3'b000 && gap_ok && baud_tick |-> tick_gap == 9'd12) else $error("tick gap not 13");
	a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
		rx_end && rx_full && !rd_clear |=> overrun_err_flag && $stable(rx_buf)) else $error("overrun lost data");
	a_rx_load: assert property (@(posedge pclk) disable iff (!presetn)
		rx_end && !rx_full |=> rx_full && rx_buf == $past(rx_shift) && rx_irq) else $error("receive load missed");
	a_clear_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd_clear && !rx_end |=> !rx_full && !overrun_err_flag && !parity_err_flag && !framing_err_flag) else $error("flags not cleared");
	a_glitch_drop: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(rx_filt) && ctrl_b[2:1] != 2'b00 && $stable(ctrl_b) |-> $past(filt_cnt) == filt_len - 7'd1)
		else $error("filter passed short pulse");
endmodule

// ===== testbench/asp_serial_peer.sv
`timescale 1ns/1ps
// Far-side serial peripheral; its line idles high like any UART line
module asp_serial_peer (
	input  wire logic pclk,     // Shared clock
	input  wire logic line_in,  // Device transmit pin
	output logic      line_out  // Device receive pin
);
	initial line_out = 1'b1;

	// One frame, LSB first; bad_p or bad_s corrupt parity or first stop on request
	task automatic send(input logic [7:0] d, input int bc, input bit pe, ev, input int ns, input bit bad_p, bad_s);
		logic [11:0] f;
		int          i;
		f = 12'hFFF;
		f[8:0] = {d, 1'b0};
		if (pe)
			f[9] = (ev ? ^d : ~^d) ^ bad_p;
		f[9 + int'(pe)] = ~bad_s;
		for (i = 0; i < 9 + int'(pe) + ns; i++) begin
			line_out <= f[i];
			repeat (bc) @(posedge pclk);
		end
		line_out <= 1'b1;
	endtask

	// Low pulse of n cycles, used as line noise
	task automatic pulse(input int n);
		line_out <= 1'b0;
		repeat (n) @(posedge pclk);
		line_out <= 1'b1;
	endtask

	// Samples nb bits at mid-bit after a falling edge; w is the start bit width
	task automatic recv(input int bc, input int nb, output logic [23:0] b, output int w);
		int c;
		b = 24'h0;
		w = 0;
		c = 0;
		while (line_in !== 1'b0 && c < 20000) begin
			@(posedge pclk);
			c++;
		end
		for (c = 0; c < nb * bc; c++) begin
			@(posedge pclk);
			if (w == 0 && line_in === 1'b1)
				w = c + 1;
			if (c % bc == bc / 2)
				b[c / bc] = line_in;
		end
	endtask
endmodule

// ===== testbench/async_serial_port_bench.sv
`timescale 1ns/1ps
`include "asp_regs.svh"
module async_serial_port_bench;
	localparam logic [13:0] CA = `ASP_IDX_CTRL_A;
	localparam logic [13:0] ST = `ASP_IDX_STATUS;
	localparam logic [13:0] CB = `ASP_IDX_CTRL_B;
	localparam logic [13:0] BF = `ASP_IDX_BUFFER;
	localparam logic [13:0] PR = `ASP_IDX_PIN_ROUTE;
	logic        pclk, presetn, psel, penable, pwrite, timer4_irq, err, rx_route, tx_route;
	logic        so1, so2, pready, pslverr, tx_irq, rx_irq, peer_out;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] bits;
	logic [7:0]  d0, d1;
	int          bad_count, compares, w, t4;

	asp_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer4_irq(timer4_irq), .serial_in_first(rx_route ? 1'b1 : peer_out),
		.serial_in_second(rx_route ? peer_out : 1'b1), .serial_out_first(so1),
		.serial_out_second(so2), .tx_irq(tx_irq), .rx_irq(rx_irq));
	asp_serial_peer peer (.pclk(pclk), .line_in(tx_route ? so2 : so1), .line_out(peer_out));

	always #5 pclk = ~pclk;

	// Timer pulse every 8 cycles, so one bit spans 128 cycles in timer mode
	always @(posedge pclk) begin
		t4 <= (t4 == 7) ? 0 : t4 + 1;
		timer4_irq <= (t4 == 7);
	end

	task automatic summarize();
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic dir, input logic [13:0] idx, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= dir;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			summarize();
		end
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] v);
		apb(1'b1, idx, v);
	endtask

	task automatic rdc(input logic [13:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h0, e});
	endtask

	task automatic wait_irq(input bit rx);
		int n;
		for (n = 0; n < 20000; n++) begin
			@(posedge pclk);
			if ((rx ? rx_irq : tx_irq) === 1'b1)
				return;
		end
		bad_count++;
		summarize();
	endtask

	// Expected frame bits, start first; everything past parity is high
	function automatic logic [11:0] frm(input logic [7:0] d, input bit pe, ev);
		frm = {3'b111, d, 1'b0};
		if (pe)
			frm[9] = ev ? ^d : ~^d;
	endfunction

	// Two back-to-back characters, or one with transmit disabled mid-frame
	task automatic tx_case(input logic [2:0] bg, input int bc, input bit pe, ev, st, one);
		int          len;
		logic [11:0] m;
		len = 10 + int'(pe) + int'(st);
		m = 12'hFFF >> (12 - len);
		d0 = 8'($urandom) | 8'h01;
		d1 = 8'($urandom);
		wr(CA, 8'h00);
		wr(CA, {2'b10, st, ev, pe, bg});
		fork
			peer.recv(bc, one ? len : 2 * len, bits, w);
			begin
				rdc(ST, 8'h0C);
				wr(BF, d0);
				wait_irq(1'b0);
				rdc(ST, 8'h04);
				if (one)
					wr(CA, {2'b00, st, ev, pe, bg});
				else
					wr(BF, d1);
			end
		join
		check({20'h0, bits[11:0] & m}, {20'h0, frm(d0, pe, ev) & m});
		if (!one)
			check({20'h0, 12'(bits >> len) & m}, {20'h0, frm(d1, pe, ev) & m});
		check({31'h0, w >= 15 * bc / 16 && w <= 17 * bc / 16}, 32'h1);
		repeat (bc) @(posedge pclk);
		rdc(ST, 8'h0C);
	endtask

	task automatic rx_case(input logic [2:0] bg, input int bc, input bit pe, ev, st, input logic [1:0] fl,
		input bit bp, bs, input logic [7:0] est);
		d0 = 8'($urandom);
		wr(CA, 8'h00);
		wr(CA, {2'b01, 1'b0, ev, pe, bg});
		wr(CB, {5'h00, fl, st});
		fork
			peer.send(d0, bc, pe, ev, st ? 2 : 1, bp, bs);
			wait_irq(1'b1);
		join
		rdc(ST, est);
		rdc(BF, d0);
		rdc(ST, 8'h0C);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		rx_route = 1'b0;
		tx_route = 1'b0;
		bad_count = 0;
		compares = 0;
		void'($urandom(32'h416E754A));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ST, 8'h0C);
		rdc(BF, 8'h00);
		rdc(PR, 8'h00);
		apb(1'b0, 14'h0010, 8'h00);
		check({31'h0, err}, 32'h1);
		// Stale data must not go out once transmit is enabled
		rdc(ST, 8'h0C);
		wr(BF, 8'h5A);
		wr(CA, 8'h80);
		w = 0;
		repeat (600) begin
			@(posedge pclk);
			w += int'(so1 !== 1'b1);
		end
		check(w, 0);
		tx_case(3'b000, 208, 1'b0, 1'b0, 1'b0, 1'b0);
		tx_case(3'b000, 208, 1'b1, 1'b1, 1'b1, 1'b0);
		tx_case(3'b110, 128, 1'b1, 1'b0, 1'b0, 1'b0);
		wr(CA, 8'h00);
		wr(PR, 8'h02);
		tx_route <= 1'b1;
		tx_case(3'b001, 416, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(PR, 8'h00);
		tx_route <= 1'b0;
		tx_case(3'b111, 1536, 1'b0, 1'b0, 1'b0, 1'b1);
		rx_case(3'b000, 208, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0, 8'h1C);
		// Second character into a full buffer is dropped
		apb(1'b0, BF, 8'h00);
		fork
			peer.send(8'h3C, 208, 1'b1, 1'b0, 1, 1'b0, 1'b0);
			wait_irq(1'b1);
		join
		@(posedge pclk);
		peer.send(8'hC3, 208, 1'b1, 1'b0, 1, 1'b0, 1'b0);
		repeat (208) @(posedge pclk);
		rdc(BF, 8'h3C);
		rdc(ST, 8'h3C);
		rdc(BF, 8'h3C);
		rdc(ST, 8'h0C);
		rx_case(3'b000, 208, 1'b1, 1'b1, 1'b1, 2'b00, 1'b1, 1'b0, 8'h9C);
		rx_case(3'b110, 128, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0, 1'b1, 8'h5C);
		// Noise on the second pin is filtered out, then a slow frame passes
		wr(CA, 8'h00);
		rx_route <= 1'b1;
		wr(PR, 8'h01);
		rdc(PR, 8'h01);
		wr(CB, 8'h06);
		wr(CA, 8'h46);
		peer.pulse(120);
		repeat (3000) @(posedge pclk);
		rdc(ST, 8'h0C);
		rx_case(3'b001, 416, 1'b0, 1'b0, 1'b0, 2'b11, 1'b0, 1'b0, 8'h1C);
		summarize();
	end
endmodule
